/* brq_clkdiv.sv */
// Programmable I/O clock divider, divisor 2, 4, 6 or 8.
// Assumes div_sel is stable software state.
`timescale 1ns/100ps
module brq_clkdiv
  import brq_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic [1:0] div_sel,
  // Outputs
  output logic io_clk,
  output logic io_rise
);
  logic [2:0] count;
  logic [2:0] half;

  assign half = {1'b0, div_sel} + 3'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 3'h0;
      io_clk <= 1'b0;
      io_rise <= 1'b0;
    end else if (count + 3'h1 >= half) begin
      count <= 3'h0;
      io_clk <= ~io_clk;
      io_rise <= ~io_clk;
    end else begin
      count <= count + 3'h1;
      io_rise <= 1'b0;
    end
  end
endmodule

/* brq_handler.sv */
// Bus request and interrupt request handler with AXI4-Lite registers.
// Assumes the core pulses transaction and instruction events on aclk.
// Notes on behaviour
// [RULE_01] Requester holds request low while needing bus
// [RULE_02] Wired-OR requesters arbitrated outside
// [RULE_03] Request pin synchronised before use
// [RULE_04] Grant after current transaction when requested
// [RULE_05] Disconnected state runs no transactions
// [RULE_06] Controls float except grant and statuses
// [RULE_07] Lock flag blocks bus release
// [RULE_08] Grant removed only after request release
// [RULE_09] Four maskable lines, one nonmaskable line
// [RULE_10] One chain may watch interrupt return
// [RULE_11] Nonmaskable falling edge sets pending latch
// [RULE_12] Sample interrupts at instruction final clock
// [RULE_13] Maskable acknowledge starts on I/O clock rise
// [RULE_14] Nonmaskable vectors to fixed address
// [RULE_15] Vector status low only during acknowledge
// [RULE_16] I/O clock divides bus clock by 2-8
// [RULE_17] Global enable zero ignores maskable requests
// [RULE_18] Nonmaskable saves then clears global enable
// [RULE_19] Request through at least two flops
// [RULE_20] Pending latch cleared when service begins
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module brq_handler
  import brq_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Core events
  input wire brq_core_t core,
  // Request pins
  input wire logic ext_master_request_n,
  input wire logic [BRQ_IRQ_LINES-1:0] maskable_irq_n,
  input wire logic nmi_n,
  // Bus side outputs
  output logic bus_grant_n,
  output logic ctrl_oe_n,
  output logic first_cycle_status_n,
  output logic vector_fetch_status_n,
  output logic peripheral_side_clock,
  // Core side
  output logic bus_free,
  output logic nmi_take,
  output logic [31:0] nmi_vector,
  output logic [BRQ_IRQ_LINES-1:0] irq_taken
);
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  brq_state_t state;
  logic internal_master_request_sync;
  logic [BRQ_IRQ_LINES-1:0] irq_sync_n;
  logic bus_hold_lock_flag;
  logic global_irq_enable;
  logic saved_irq_enable;
  logic [1:0] div_sel;
  logic [BRQ_IRQ_LINES-1:0] irq_mask;
  logic io_clk;
  logic io_rise;
  logic nmi_latch;
  logic nmi_clr;
  logic [2:0] nmi_sync;
  logic [BRQ_IRQ_LINES-1:0] sampled;
  logic ack_pending;
  logic [2:0] ack_cnt;
  logic [7:0] aw_hold;
  logic aw_have;
  logic [31:0] w_hold;
  logic w_have;
  logic [3:0] wstrb_hold;

  brq_sync #(.RESET_VALUE(1'b1)) u_ext_master_request_n_sync ( // RULE_03 RULE_19
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ext_master_request_n),
    .level(internal_master_request_sync)
  );

  for (genvar i = 0; i < BRQ_IRQ_LINES; i++) begin : g_irq
    brq_sync #(.RESET_VALUE(1'b1)) u_irq_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(maskable_irq_n[i]),
      .level(irq_sync_n[i])
    );
  end

  brq_clkdiv u_div ( // RULE_16
    .aclk(aclk),
    .aresetn(aresetn),
    .div_sel(div_sel),
    .io_clk(io_clk),
    .io_rise(io_rise)
  );

  // Clockless edge latch; clear level held until the latch reads low
  always_ff @(negedge nmi_n or posedge nmi_clr) begin // RULE_11
    if (nmi_clr) begin
      nmi_latch <= 1'b0;
    end else begin
      nmi_latch <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_sync <= 3'h0;
    end else begin
      nmi_sync <= {nmi_sync[1:0], nmi_latch};
    end
  end

  // Bus ownership sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= BRQ_ST_RUN;
    end else begin
      case (state)
        BRQ_ST_RUN: begin
          if (core.txn_start && !internal_master_request_sync && !bus_hold_lock_flag) begin
            state <= BRQ_ST_FINISH; // RULE_04 RULE_07
          end else if (io_rise && ack_pending) begin
            state <= BRQ_ST_ACK;
          end
        end
        BRQ_ST_FINISH: begin
          if (core.txn_done) begin
            state <= BRQ_ST_DISC; // RULE_05
          end
        end
        BRQ_ST_DISC: begin
          if (internal_master_request_sync) begin
            state <= BRQ_ST_RUN; // RULE_08
          end
        end
        BRQ_ST_ACK: begin
          if (io_rise && ack_cnt == 3'h3) begin
            state <= BRQ_ST_RUN;
          end
        end
        default: state <= BRQ_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state != BRQ_ST_ACK) begin
      ack_cnt <= 3'h0;
    end else if (io_rise) begin
      ack_cnt <= ack_cnt + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_grant_n <= 1'b1;
      ctrl_oe_n <= 1'b0;
      bus_free <= 1'b1;
      vector_fetch_status_n <= 1'b1;
      first_cycle_status_n <= 1'b1;
      peripheral_side_clock <= 1'b0;
    end else begin
      bus_grant_n <= !(state == BRQ_ST_DISC);
      ctrl_oe_n <= (state == BRQ_ST_DISC); // RULE_06
      bus_free <= (state == BRQ_ST_RUN);
      vector_fetch_status_n <= !(state == BRQ_ST_ACK); // RULE_15
      first_cycle_status_n <= !(state == BRQ_ST_ACK);
      peripheral_side_clock <= io_clk;
    end
  end

  // Interrupt sampling at the last clock of an instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sampled <= '0;
      ack_pending <= 1'b0;
      irq_taken <= '0;
      nmi_take <= 1'b0;
      nmi_clr <= 1'b1;
      nmi_vector <= 32'h0;
    end else begin
      nmi_take <= 1'b0;
      if (nmi_clr && !nmi_sync[2]) begin
        nmi_clr <= 1'b0;
      end
      if (state == BRQ_ST_ACK && io_rise && ack_cnt == 3'h3) begin
        ack_pending <= 1'b0;
        irq_taken <= sampled;
      end else begin
        irq_taken <= '0;
      end
      if (core.instr_last_clk && state == BRQ_ST_RUN) begin // RULE_12
        if (nmi_sync[2] && !nmi_clr) begin
          nmi_take <= 1'b1; // RULE_14
          nmi_vector <= BRQ_NMI_VECTOR;
          nmi_clr <= 1'b1; // RULE_20
        end else if (global_irq_enable && |(~irq_sync_n & irq_mask) && !ack_pending) begin
          sampled <= ~irq_sync_n & irq_mask; // RULE_09 RULE_17
          ack_pending <= 1'b1; // RULE_13
        end
      end
    end
  end

  // Enable flags and lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_irq_enable <= 1'b0;
      saved_irq_enable <= 1'b0;
      bus_hold_lock_flag <= 1'b0;
    end else begin
      if (core.set_lock) begin
        bus_hold_lock_flag <= 1'b1;
      end else if (core.clear_lock) begin
        bus_hold_lock_flag <= 1'b0;
      end
      if (nmi_take) begin
        saved_irq_enable <= global_irq_enable; // RULE_18
        global_irq_enable <= 1'b0;
      end else if (core.restore_int) begin
        global_irq_enable <= saved_irq_enable;
      end else if (core.enable_int) begin
        global_irq_enable <= 1'b1;
      end else if (core.disable_int) begin
        global_irq_enable <= 1'b0;
      end
    end
  end

  // AXI4-Lite write side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_hold <= 8'h0;
      w_hold <= 32'h0;
      wstrb_hold <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
      div_sel <= BRQ_DIV_RESET;
      irq_mask <= '1;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have <= 1'b1;
        aw_hold <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have <= 1'b1;
        w_hold <= s_wdata;
        wstrb_hold <= s_wstrb;
      end
      if (aw_have && w_have && !s_bvalid) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= (aw_hold == REG_CTRL) ? 2'h0 : 2'h2;
        if (aw_hold == REG_CTRL && wstrb_hold[0]) begin
          div_sel <= w_hold[1:0];
          irq_mask <= w_hold[7:4];
        end
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  assign s_awready = !aw_have && !s_bvalid;
  assign s_wready = !w_have && !s_bvalid;
  assign s_arready = !s_rvalid;

  // AXI4-Lite read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= 2'h0;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp <= 2'h0;
      case (s_araddr)
        REG_CTRL: s_rdata <= {24'h0, irq_mask, 2'h0, div_sel};
        REG_STATUS: s_rdata <= {21'h0, state, ack_pending, nmi_sync[2],
                                saved_irq_enable, global_irq_enable, 1'b0,
                                bus_hold_lock_flag, !internal_master_request_sync};
        default: begin
          s_rdata <= 32'h0;
          s_rresp <= 2'h2;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  grant_follows_disc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == BRQ_ST_DISC |=> !bus_grant_n && ctrl_oe_n) else $error("grant wrong"); // RULE_06
  lock_blocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == BRQ_ST_RUN && bus_hold_lock_flag |=> state != BRQ_ST_FINISH)
    else $error("lock ignored"); // RULE_07
  release_needs_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == BRQ_ST_DISC && !internal_master_request_sync |=> state == BRQ_ST_DISC)
    else $error("early release"); // RULE_08
  nmi_vector_a: assert property (@(posedge aclk) disable iff (!aresetn)
    nmi_take |-> nmi_vector == BRQ_NMI_VECTOR) else $error("bad vector"); // RULE_14
  nmi_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    nmi_take |=> !global_irq_enable && saved_irq_enable == $past(global_irq_enable))
    else $error("enable not saved"); // RULE_18
  ack_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == BRQ_ST_ACK |=> !vector_fetch_status_n) else $error("status high"); // RULE_15
  ack_on_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == BRQ_ST_RUN ##1 state == BRQ_ST_ACK |-> $past(io_rise))
    else $error("ack off edge"); // RULE_13
  finish_then_disc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == BRQ_ST_FINISH && core.txn_done |=> state == BRQ_ST_DISC ##1 !bus_grant_n)
    else $error("no disconnect"); // RULE_04
  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !global_irq_enable && !ack_pending |=> !ack_pending) else $error("masked taken"); // RULE_17
endmodule

/* brq_partner.sv */
// Model of one external bus master that borrows the processor bus.
// Assumes go and the grant pin are synchronous to aclk.
`timescale 1ns/100ps
module brq_partner #(
  parameter int HOLD = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control and bus pins
  input wire logic go,
  input wire logic bus_grant_n,
  output logic ext_master_request_n
);
  int cnt;
  // Sole requester, so outside arbitration is trivially resolved
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_master_request_n <= 1'b1;
      cnt <= 0;
    end else if (go) begin
      ext_master_request_n <= 1'b0;
      cnt <= 0;
    end else if (!ext_master_request_n && !bus_grant_n) begin
      cnt <= cnt + 1;
      if (cnt == HOLD) begin
        ext_master_request_n <= 1'b1;
      end
    end
  end
endmodule

/* brq_pkg.sv */
// Package for the bus and interrupt request handler.
// Assumes a single processor bus clock at 20 MHz.
package brq_pkg;
  localparam logic [31:0] BRQ_NMI_VECTOR = 32'h0000_0066;
  localparam int BRQ_SYNC_STAGES = 3;
  localparam logic [1:0] BRQ_DIV_RESET = 2'h0;
  localparam int BRQ_IRQ_LINES = 4;

  typedef enum logic [3:0] {
    BRQ_ST_RUN = 4'h1,
    BRQ_ST_FINISH = 4'h2,
    BRQ_ST_DISC = 4'h4,
    BRQ_ST_ACK = 4'h8
  } brq_state_t;

  typedef struct packed {
    logic txn_start;
    logic txn_done;
    logic instr_last_clk;
    logic set_lock;
    logic clear_lock;
    logic enable_int;
    logic disable_int;
    logic restore_int;
  } brq_core_t;
endpackage

/* brq_sync.sv */
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the input is asynchronous to aclk.
`timescale 1ns/100ps
module brq_sync
  import brq_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  logic [BRQ_SYNC_STAGES-1:0] stage;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage <= {BRQ_SYNC_STAGES{RESET_VALUE}};
    end else begin
      stage <= {stage[BRQ_SYNC_STAGES-2:0], pin};
    end
  end

  // Only the last two stages are compared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= RESET_VALUE;
    end else if (stage[1] == stage[2]) begin
      level <= stage[2];
    end
  end
endmodule

/* testbench.sv */
// Self-checking bench for the bus and interrupt request handler.
// Assumes a 20 MHz aclk and the partner model as the bus borrower.
`timescale 1ns/100ps
module testbench;
  import brq_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, go = 1'b0, nmi_n = 1'b1;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, nmi_vector;
  brq_core_t core = '0;
  logic [3:0] irq_n = 4'hF, irq_taken;
  logic req_n, grant_n, oe_n, m1_n, vf_n, pclk, bus_free, nmi_take;
  int fails = 0, comparisons = 0;
  always #25 aclk = ~aclk;
  brq_handler DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .core(core),
    .ext_master_request_n(req_n), .maskable_irq_n(irq_n), .nmi_n(nmi_n),
    .bus_grant_n(grant_n), .ctrl_oe_n(oe_n), .first_cycle_status_n(m1_n),
    .vector_fetch_status_n(vf_n), .peripheral_side_clock(pclk), .bus_free(bus_free),
    .nmi_take(nmi_take), .nmi_vector(nmi_vector), .irq_taken(irq_taken));
  brq_partner #(.HOLD(8)) master (.aclk(aclk), .aresetn(aresetn), .go(go),
    .bus_grant_n(grant_n), .ext_master_request_n(req_n));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic pulse(input logic [7:0] c);
    core <= brq_core_t'(c);
    @(posedge aclk);
    core <= '0;
    @(posedge aclk);
  endtask
  task automatic bus_txn();
    pulse(8'h80);
    pulse(8'h40);
  endtask
  task automatic wait_grant(input logic v);
    for (int n = 0; n < 40 && grant_n !== v; n++) @(posedge aclk);
  endtask
  task automatic instr_end(output int took);
    took = 0;
    core <= brq_core_t'(8'h20);
    for (int n = 0; n < 6; n++) begin
      @(posedge aclk);
      core <= '0;
      if (nmi_take !== 1'b0) took++;
    end
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(8'h00, d, r);
    chk("ctrl reset", 32'h0000_00F0, d);
    axi_rd(8'h10, d, r);
    chk("unmapped read resp", 32'h2, {30'h0, r});
    axi_wr(8'h14, 32'hFFFF_FFFF, r);
    chk("unmapped write resp", 32'h2, {30'h0, r});
  endtask
  task automatic t_divide();
    logic [1:0] r;
    time t0;
    for (int s = 0; s < 4; s++) begin
      axi_wr(8'h00, 32'h0000_00F0 | s, r);
      repeat (20) @(posedge aclk);
      @(posedge pclk);
      t0 = $time;
      @(posedge pclk);
      chk("io clock period", 2 * (s + 1), 32'(($time - t0) / 50));
    end
    axi_wr(8'h00, 32'h0000_00F0, r);
  endtask
  task automatic t_bus();
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (6) @(posedge aclk);
    bus_txn();
    wait_grant(1'b0);
    chk("grant", 0, grant_n);
    @(posedge aclk);
    chk("controls floated", 1, oe_n);
    chk("statuses driven", 2'b11, {m1_n, vf_n});
    chk("bus free", 0, bus_free);
    wait_grant(1'b1);
    chk("request gone at regain", 1, req_n);
    @(posedge aclk);
    chk("controls back", 0, oe_n);
  endtask
  task automatic t_lock();
    pulse(8'h10);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (6) @(posedge aclk);
    bus_txn();
    repeat (12) @(posedge aclk);
    chk("grant while locked", 1, grant_n);
    pulse(8'h08);
    bus_txn();
    wait_grant(1'b0);
    chk("grant after unlock", 0, grant_n);
    wait_grant(1'b1);
  endtask
  task automatic t_nmi();
    logic [31:0] d;
    logic [1:0] r;
    int took;
    pulse(8'h04);
    nmi_n <= 1'b0;
    @(posedge aclk);
    nmi_n <= 1'b1;
    repeat (4) @(posedge aclk);
    instr_end(took);
    chk("nmi taken once", 1, took);
    chk("nmi vector", BRQ_NMI_VECTOR, nmi_vector);
    chk("no ack for nmi", 1, vf_n);
    axi_rd(8'h04, d, r);
    chk("enable flags", 2'b10, d[4:3]);
    chk("nmi pending cleared", 0, d[5]);
    instr_end(took);
    chk("no second entry", 0, took);
  endtask
  task automatic t_irq();
    int n = 0, seen = 0;
    pulse(8'h02);
    irq_n <= 4'hE;
    repeat (5) @(posedge aclk);
    pulse(8'h20);
    repeat (20) @(posedge aclk);
    chk("ack while disabled", 1, vf_n);
    pulse(8'h04);
    pulse(8'h20);
    for (int k = 0; k < 40 && vf_n !== 1'b0; k++) @(posedge aclk);
    chk("ack starts", 0, vf_n);
    chk("first cycle status in ack", 0, m1_n);
    while (vf_n === 1'b0 && n < 40) begin
      @(posedge aclk);
      n++;
      if (irq_taken === 4'h1) seen++;
    end
    chk("ack length ok", 1, n >= 7 && n <= 9);
    chk("line 0 taken", 1, seen);
    irq_n <= 4'hF;
    repeat (4) @(posedge aclk);
  endtask

  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_divide();
    t_bus();
    t_lock();
    t_nmi();
    t_irq();
    final_report();
  end
endmodule
